/* File: scan_mode_pkg.sv */
// Contract
// - the progressive static mode table is used only while progressive scan is chosen and either the adaptive select is zero or the static code is a film start.
// - static code 0000 shows a compensated c+d frame at phase 0 and a compensated a+b frame at phase 2/0.
// - code 0001 shows a film c+d frame at phase 0 and a film a+b frame at phase 2/0.
// - code 0010 shows a film a+b frame at phase 0 and a film c+d frame at phase 2/0.
// - code 0011 weaves A now with B before at phase 0 and A with B now at 2/0, and 0100 does the same with interpolated partners.
// - code 1110 shows a film a+b frame at both phases.
// - code 1111 shows a film c+d frame at phase 0 and an NTSC c-field film frame at phase 2/0.
// - static 0000 with adaptive 000 stays fixed in camera-mode compensation.
// - with adaptive 000, static 0001 forces PAL film phase 0 and 0010 forces phase 1, with no switching.
// - static 0010 with adaptive 100 keeps code 0010 until a film is detected, then behaves as 0001 with adaptive 100.
// - static 1110 or 1111 with adaptive 100 chooses between 1110 and 1111 from the detected phase.
// - adaptive 101 with a PAL start acts as 100 but picks 0011 whenever global motion is zero.
// - adaptive 101 with an NTSC start picks among 1110, 1111 and 0011, using 0011 when global motion is zero.
// - global motion and film detection flags are readable by the host over the register bus.
package scan_mode_pkg;
  localparam logic [3:0] code_camera = 4'h0;
  localparam logic [3:0] code_pal_ph0 = 4'h1;
  localparam logic [3:0] code_pal_ph1 = 4'h2;
  localparam logic [3:0] code_frame_ab = 4'h3;
  localparam logic [3:0] code_frame_median = 4'h4;
  localparam logic [3:0] code_simple50 = 4'h5;
  localparam logic [3:0] code_field_aa = 4'hC;
  localparam logic [3:0] code_field_bb = 4'hD;
  localparam logic [3:0] code_ntsc_ph0 = 4'hE;
  localparam logic [3:0] code_ntsc_ph1 = 4'hF;

  localparam logic [2:0] adapt_off = 3'h0;
  localparam logic [2:0] adapt_film1 = 3'h4;
  localparam logic [2:0] adapt_film2 = 3'h5;

  // register byte offsets
  localparam logic [3:0] addr_mode = 4'h0;
  localparam logic [3:0] addr_status = 4'h4;
  localparam logic [3:0] addr_active = 4'h8;
  // mode register fields
  localparam int mode_static_lsb = 0;
  localparam int mode_adapt_lsb = 4;
  localparam int mode_scan_bit = 7;
  localparam logic [7:0] mode_reset = 8'h00;
  // status register fields
  localparam int stat_motion_bit = 0;
  localparam int stat_type_bit = 1;
  localparam int stat_phase_bit = 2;
  localparam int stat_detect_bit = 3;
  localparam int stat_locked_bit = 4;
  localparam int stat_valid_bit = 5;

  // frame content kinds
  typedef enum logic [3:0] {
    frm_mc_cd, frm_mc_ab, frm_film_cd, frm_film_ab, frm_film_nc,
    frm_weave_ab_prev, frm_weave_ab_now, frm_weave_a_bi_prev, frm_weave_ai_b_now,
    frm_a_ai, frm_bi_b, frm_bi_b_prev, frm_none
  } frame_kind_t;

  typedef struct packed {
    logic global_motion_flag;
    logic film_type_flag;
    logic film_phase_flag;
    logic film_detected_flag;
  } detect_flags_t;

  typedef struct packed {
    frame_kind_t phase0;
    frame_kind_t phase20;
    logic valid;
  } frame_sel_t;
endpackage

/* File: progressive_scan_mode_selector.sv */
`timescale 1ns/1ps
module progressive_scan_mode_selector (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire scan_mode_pkg::detect_flags_t detect,
  output logic [3:0] active_mode_code,
  output scan_mode_pkg::frame_kind_t frame_phase0,
  output scan_mode_pkg::frame_kind_t frame_phase20,
  output logic frame_valid
);

  typedef enum logic [1:0] {auto_idle, auto_locked} auto_state_t;

  typedef struct packed {
    logic [3:0] master_static_mode_code;
    logic [2:0] adaptive_mode_select;
    logic scan_pattern_select;
    auto_state_t auto_state;
    logic [3:0] locked_code;
    logic [3:0] active_code;
    scan_mode_pkg::frame_sel_t frames;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  state_t cur;
  state_t next_cur;

  function automatic logic is_pal(input logic [3:0] c);
    is_pal = (c == scan_mode_pkg::code_pal_ph0) || (c == scan_mode_pkg::code_pal_ph1);
  endfunction

  function automatic logic is_ntsc(input logic [3:0] c);
    is_ntsc = (c == scan_mode_pkg::code_ntsc_ph0) || (c == scan_mode_pkg::code_ntsc_ph1);
  endfunction

  // progressive frame table for one mode code
  function automatic scan_mode_pkg::frame_sel_t frames_of(input logic [3:0] c);
    scan_mode_pkg::frame_sel_t f;
    f.valid = 1'b1;
    f.phase0 = scan_mode_pkg::frm_none;
    f.phase20 = scan_mode_pkg::frm_none;
    unique case (c)
      scan_mode_pkg::code_camera: begin
        f.phase0 = scan_mode_pkg::frm_mc_cd;
        f.phase20 = scan_mode_pkg::frm_mc_ab;
      end
      scan_mode_pkg::code_pal_ph0: begin
        f.phase0 = scan_mode_pkg::frm_film_cd;
        f.phase20 = scan_mode_pkg::frm_film_ab;
      end
      scan_mode_pkg::code_pal_ph1: begin
        f.phase0 = scan_mode_pkg::frm_film_ab;
        f.phase20 = scan_mode_pkg::frm_film_cd;
      end
      scan_mode_pkg::code_frame_ab: begin
        f.phase0 = scan_mode_pkg::frm_weave_ab_prev;
        f.phase20 = scan_mode_pkg::frm_weave_ab_now;
      end
      scan_mode_pkg::code_frame_median: begin
        f.phase0 = scan_mode_pkg::frm_weave_a_bi_prev;
        f.phase20 = scan_mode_pkg::frm_weave_ai_b_now;
      end
      scan_mode_pkg::code_simple50: begin
        f.phase0 = scan_mode_pkg::frm_a_ai;
        f.phase20 = scan_mode_pkg::frm_bi_b;
      end
      scan_mode_pkg::code_field_aa: begin
        f.phase0 = scan_mode_pkg::frm_a_ai;
        f.phase20 = scan_mode_pkg::frm_a_ai;
      end
      scan_mode_pkg::code_field_bb: begin
        f.phase0 = scan_mode_pkg::frm_bi_b_prev;
        f.phase20 = scan_mode_pkg::frm_bi_b_prev;
      end
      scan_mode_pkg::code_ntsc_ph0: begin
        f.phase0 = scan_mode_pkg::frm_film_ab;
        f.phase20 = scan_mode_pkg::frm_film_ab;
      end
      scan_mode_pkg::code_ntsc_ph1: begin
        f.phase0 = scan_mode_pkg::frm_film_cd;
        f.phase20 = scan_mode_pkg::frm_film_nc;
      end
      // unlisted codes give no defined frame; flagged invalid
      default: f.valid = 1'b0;
    endcase
    frames_of = f;
  endfunction

  logic wb_req;
  logic mode_write;
  logic [7:0] mode_wdata;
  logic [3:0] film_code;
  logic [3:0] chosen;
  logic film_start;

  assign wb_req = wb_cyc_i && wb_stb_i && !cur.ack;
  assign mode_write = wb_req && wb_we_i && (wb_adr_i == scan_mode_pkg::addr_mode) && wb_sel_i[0];
  assign mode_wdata = wb_dat_i[7:0];

  always_comb begin
    next_cur = cur;
    film_code = 4'h0;
    chosen = cur.master_static_mode_code;
    film_start = 1'b0;
    next_cur.ack = wb_req;
    if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        scan_mode_pkg::addr_mode: next_cur.rdata = {24'h000000,
          cur.scan_pattern_select, cur.adaptive_mode_select, cur.master_static_mode_code};
        scan_mode_pkg::addr_status: begin
          next_cur.rdata = 32'h00000000;
          next_cur.rdata[scan_mode_pkg::stat_motion_bit] = detect.global_motion_flag;
          next_cur.rdata[scan_mode_pkg::stat_type_bit] = detect.film_type_flag;
          next_cur.rdata[scan_mode_pkg::stat_phase_bit] = detect.film_phase_flag;
          next_cur.rdata[scan_mode_pkg::stat_detect_bit] = detect.film_detected_flag;
          next_cur.rdata[scan_mode_pkg::stat_locked_bit] = (cur.auto_state == auto_locked);
          next_cur.rdata[scan_mode_pkg::stat_valid_bit] = cur.frames.valid;
        end
        scan_mode_pkg::addr_active: next_cur.rdata = {28'h0000000, cur.active_code};
        default: next_cur.rdata = 32'h00000000;
      endcase
    end

    // film code follows the detected phase within the starting family; the type flag is not used
    if (is_pal(cur.master_static_mode_code)) begin
      film_code = detect.film_phase_flag ? scan_mode_pkg::code_pal_ph1
                                         : scan_mode_pkg::code_pal_ph0;
      film_start = 1'b1;
    end else if (is_ntsc(cur.master_static_mode_code)) begin
      film_code = detect.film_phase_flag ? scan_mode_pkg::code_ntsc_ph1
                                         : scan_mode_pkg::code_ntsc_ph0;
      film_start = 1'b1;
    end

    // only film starts engage the automatic modes; other codes stay static
    unique case (cur.adaptive_mode_select)
      scan_mode_pkg::adapt_off: chosen = cur.master_static_mode_code;
      scan_mode_pkg::adapt_film1, scan_mode_pkg::adapt_film2: begin
        if (film_start) begin
          if (cur.auto_state == auto_locked) begin
            chosen = cur.locked_code;
          end else if (detect.film_detected_flag) begin
            chosen = film_code;
            next_cur.locked_code = film_code;
            next_cur.auto_state = auto_locked;
          end
          if (cur.adaptive_mode_select == scan_mode_pkg::adapt_film2 &&
              !detect.global_motion_flag) begin
            chosen = scan_mode_pkg::code_frame_ab;
          end
        end
      end
      default: chosen = cur.master_static_mode_code;
    endcase

    next_cur.active_code = chosen;
    // table applies only for progressive output with the adaptive select at zero or a film start code
    if (cur.scan_pattern_select &&
        (cur.adaptive_mode_select == scan_mode_pkg::adapt_off ||
         film_start)) begin
      next_cur.frames = frames_of(chosen);
    end else begin
      next_cur.frames.valid = 1'b0;
      next_cur.frames.phase0 = scan_mode_pkg::frm_none;
      next_cur.frames.phase20 = scan_mode_pkg::frm_none;
    end

    // a host write that changes the mode register value releases any latched film choice
    if (mode_write) begin
      next_cur.master_static_mode_code = mode_wdata[scan_mode_pkg::mode_static_lsb +: 4];
      next_cur.adaptive_mode_select = mode_wdata[scan_mode_pkg::mode_adapt_lsb +: 3];
      next_cur.scan_pattern_select = mode_wdata[scan_mode_pkg::mode_scan_bit];
      if (mode_wdata != {cur.scan_pattern_select, cur.adaptive_mode_select,
                         cur.master_static_mode_code}) begin
        next_cur.auto_state = auto_idle;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cur.master_static_mode_code <= scan_mode_pkg::mode_reset[3:0];
      cur.adaptive_mode_select <= scan_mode_pkg::mode_reset[6:4];
      cur.scan_pattern_select <= scan_mode_pkg::mode_reset[7];
      cur.auto_state <= auto_idle;
      cur.locked_code <= 4'h0;
      cur.active_code <= 4'h0;
      cur.frames.phase0 <= scan_mode_pkg::frm_none;
      cur.frames.phase20 <= scan_mode_pkg::frm_none;
      cur.frames.valid <= 1'b0;
      cur.ack <= 1'b0;
      cur.rdata <= 32'h00000000;
    end else begin
      cur <= next_cur;
    end
  end

  assign wb_ack_o = cur.ack;
  assign wb_dat_o = cur.rdata;
  assign active_mode_code = cur.active_code;
  assign frame_phase0 = cur.frames.phase0;
  assign frame_phase20 = cur.frames.phase20;
  assign frame_valid = cur.frames.valid;

endmodule // progressive_scan_mode_selector

/* File: wb_host_model.sv */
`timescale 1ns/1ps
module wb_host_model (
  input wire logic clk,
  input wire logic ack,
  input wire logic [31:0] rdata,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [3:0] adr,
  output logic [3:0] sel,
  output logic [31:0] wdata
);
  initial {cyc, stb, we, adr, sel, wdata} = '0;
  // a released bus shows the complement of its last value, never a stale copy
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q, output bit ok);
    int n = 0;
    {cyc, stb, we, adr, sel, wdata} <= {2'b11, w, a, 4'hF, d};
    ok = 1'b0;
    while (!ok && n < 64) begin
      @(posedge clk);
      ok = ack;
      n++;
    end
    q = rdata;
    {cyc, stb, we, adr, sel, wdata} <= {2'b00, ~{w, a, 4'hF, d}};
    @(posedge clk);
  endtask
endmodule // wb_host_model

/* File: scan_mode_props.sv */
`timescale 1ns/1ps
module scan_mode_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire scan_mode_pkg::detect_flags_t detect,
  input wire logic [3:0] active_mode_code,
  input wire scan_mode_pkg::frame_kind_t frame_phase0,
  input wire scan_mode_pkg::frame_kind_t frame_phase20,
  input wire logic frame_valid
);
  // shadow of the mode byte; frame kinds below are package enum indices
  logic [7:0] mode;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) mode <= 8'h00;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 4'h0) mode <= wb_dat_i[7:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer wrong");
  a_camera_fixed: assert property ($past(mode) == 8'h80 |->
    {active_mode_code, frame_phase0, frame_phase20} == 12'h001) else $error("camera");
  a_pal_phase0: assert property ($past(mode) == 8'h81 |->
    {active_mode_code, frame_phase0, frame_phase20} == 12'h123) else $error("pal 0");
  a_pal_phase1: assert property ($past(mode) == 8'h82 |->
    {active_mode_code, frame_phase0, frame_phase20} == 12'h232) else $error("pal 1");
  a_frame_weave: assert property ($past(mode) == 8'h83 |->
    {active_mode_code, frame_phase0, frame_phase20} == 12'h356) else $error("weave");
  a_ntsc_phase0: assert property ($past(mode) == 8'h8E |->
    {active_mode_code, frame_phase0, frame_phase20} == 12'hE33) else $error("ntsc 0");
  a_ntsc_phase1: assert property ($past(mode) == 8'h8F |->
    {active_mode_code, frame_phase0, frame_phase20} == 12'hF24) else $error("ntsc 1");
  a_table_gate: assert property ($past(!mode[7]) |-> !frame_valid)
    else $error("valid in interlaced");
  a_still_override: assert property ($past(mode[7:4] == 4'hD && !detect.global_motion_flag &&
    mode[3:0] inside {4'h1, 4'h2, 4'hE, 4'hF}) |-> active_mode_code == 4'h3) else $error("still");
endmodule // scan_mode_props
bind progressive_scan_mode_selector scan_mode_props i_props (
  .clk(clk),
  .nrst(nrst),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o),
  .detect(detect),
  .active_mode_code(active_mode_code),
  .frame_phase0(frame_phase0),
  .frame_phase20(frame_phase20),
  .frame_valid(frame_valid)
);

/* File: progressive_scan_mode_selector_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED at %0t: %s", $time, m); end end
module progressive_scan_mode_selector_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic lk = 1'b0;
  logic cyc, stb, we, ack, fv;
  logic [3:0] adr, sel, act, lc;
  logic [31:0] dw, dr, q, r;
  logic [7:0] mode = 8'h00;
  scan_mode_pkg::detect_flags_t det = 4'h0;
  scan_mode_pkg::frame_kind_t f0, f20;
  int n_errors = 0;
  int total_checks = 0;
  int seed = 42;
  // per static code: valid, then both frame kinds as package enum indices
  logic [8:0] frames_of [16] = '{9'h101, 9'h123, 9'h132, 9'h156, 9'h178, 9'h19A, 9'h0, 9'h0,
    9'h0, 9'h0, 9'h0, 9'h0, 9'h199, 9'h1BB, 9'h133, 9'h124};
  // mode byte, then detect flags
  logic [11:0] seq [20] = '{12'h800, 12'h81B, 12'h819, 12'h82B, 12'h830, 12'h840, 12'h85F,
    12'h8C0, 12'h8D0, 12'h8E0, 12'h8F0, 12'h0E0, 12'hC18, 12'hC11, 12'hC1B, 12'hC2B,
    12'hCE8, 12'hCFB, 12'hD19, 12'hDF1};
  logic [3:0] codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hC, 4'hD, 4'hE, 4'hF};
  always #4 clk = ~clk;
  progressive_scan_mode_selector i_dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .detect(det), .active_mode_code(act), .frame_phase0(f0), .frame_phase20(f20),
    .frame_valid(fv));
  wb_host_model i_host (.clk(clk), .ack(ack), .rdata(dr), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .wdata(dw));
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    bit ok;
    i_host.xfer(w, a, d, q, ok);
    if (!ok) begin
      n_errors++;
      print_verdict();
    end
    if (w && a == 4'h0 && d[7:0] != mode) lk = 1'b0;
    if (w && a == 4'h0) mode = d[7:0];
  endtask
  task automatic check_all();
    logic [3:0] c;
    logic [8:0] t;
    repeat (2) @(posedge clk);
    c = mode[3:0];
    if (mode[7:5] == 3'b110 && c inside {4'h1, 4'h2, 4'hE, 4'hF}) begin
      if (!lk && det.film_detected_flag) lc = (c[3] ? 4'hE : 4'h1) + det.film_phase_flag;
      lk = lk | det.film_detected_flag;
      if (lk) c = lc;
      if (mode[4] && !det.global_motion_flag) c = 4'h3;
    end
    t = mode[7] ? frames_of[c] : 9'h0;
    `CHK(act, c, "active code")
    `CHK(fv, t[8], "frame valid")
    if (t[8]) `CHK({f0, f20}, t[7:0], "frame kinds")
    bus(1'b0, 4'h4, 32'h0);
    // status holds detect flags in reverse of the struct order
    `CHK(q[5:0], {t[8], lk, det[0], det[1], det[2], det[3]}, "status")
    bus(1'b0, 4'hC, 32'h0);
    `CHK(q, 32'h0, "unmapped read")
    // the mode byte is only ever seen over the bus here; the effective code is also checked on its port
    bus(1'b0, 4'h0, 32'h0);
    `CHK(q, {24'h0, mode}, "mode readback")
    bus(1'b0, 4'h8, 32'h0);
    `CHK(q, {28'h0, c}, "active readback")
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    foreach (seq[i]) begin
      det <= seq[i][3:0];
      bus(1'b1, 4'h0, {24'h0, seq[i][11:4]});
      check_all();
    end
    repeat (200) begin
      r = $random(seed);
      case (r[1:0])
        2'd0: bus(1'b1, 4'h0, {24'h0, 3'b110, r[6], codes[{r[5], 2'b00, ~r[5]} + r[4]]});
        2'd1: bus(1'b1, 4'h0, {24'h0, r[7], 3'h0, codes[r[11:8] % 10]});
        2'd2: det <= r[15:12];
        default: bus(1'b1, r[2] ? 4'h4 : 4'hC, r);
      endcase
      check_all();
    end
    print_verdict();
  end
endmodule // progressive_scan_mode_selector_tb
